// ===== design/crs_pkg.sv
// package with register map, reset values and field positions of the clock route switch bank
package crs_pkg;
  // =====================================================
  // register indices as printed, byte address is four times the index
  localparam logic [7:0] IDX_BOARD_ID = 8'h00;
  localparam logic [7:0] IDX_EXT_ID_HIGH = 8'h02;
  localparam logic [7:0] IDX_EXT_ID_MID = 8'h03;
  localparam logic [7:0] IDX_EXT_ID_LOW = 8'h04;
  localparam logic [7:0] IDX_FAB_REV = 8'h05;
  localparam logic [7:0] IDX_ASSEMBLY_REV = 8'h06;
  localparam logic [7:0] IDX_FIRMWARE_REV = 8'h07;
  localparam logic [7:0] IDX_T1_ROUTE = 8'h11;
  localparam logic [7:0] IDX_E1_ROUTE = 8'h12;
  localparam logic [7:0] IDX_LINK_A = 8'h13;
  localparam logic [7:0] IDX_LINK_B = 8'h14;
  localparam logic [7:0] IDX_LEVEL = 8'h15;
  localparam int ADDR_WIDTH = 8;
  localparam int WORD_SHIFT = 2;
  localparam int FIELD_WIDTH = 4;
  // =====================================================
  // reset values of writable registers
  localparam logic [3:0] RST_T1_ROUTE = 4'hf;
  localparam logic [3:0] RST_E1_ROUTE = 4'h3;
  localparam logic [3:0] RST_LINK_A = 4'hf;
  localparam logic [3:0] RST_LINK_B = 4'h3;
  localparam logic [3:0] RST_LEVEL = 4'h6;
  // =====================================================
  // field positions
  localparam int BIT_MASTER = 3;
  localparam int BIT_TX = 2;
  localparam int BIT_RXSYS = 1;
  localparam int BIT_TXSYS = 0;
  localparam int BIT_CELL_HDR = 2;
  localparam int BIT_TDM_HDR = 1;
  localparam int BIT_BP_SEL = 0;
  // =====================================================
  // number of writable registers
  localparam int NUM_RW = 5;
  typedef logic [3:0] crs_nib_t;
endpackage : crs_pkg

// ===== design/crs_bus_if.sv
// interface between the apb decoder and the register storage
interface crs_bus_if;
  logic wrEn;
  logic [2:0] wrSel;
  logic [3:0] wrData;
  logic [19:0] regs;
  modport decoder (output wrEn, output wrSel, output wrData, input regs);
  modport store (input wrEn, input wrSel, input wrData, output regs);
endinterface : crs_bus_if

// ===== design/crs_reg_store.sv
// storage of the five writable switch control registers
module crs_reg_store (
  input wire logic clk,
  input wire logic reset,
  crs_bus_if.store bus
);
  typedef struct packed {
    logic [19:0] regs;
  } crs_store_s;

  localparam logic [19:0] RESET_ALL = {crs_pkg::RST_LEVEL, crs_pkg::RST_LINK_B, crs_pkg::RST_LINK_A,
    crs_pkg::RST_E1_ROUTE, crs_pkg::RST_T1_ROUTE};

  crs_store_s state;
  crs_store_s next_state;

  // =====================================================
  // next value: one nibble per register, selected by index
  always_comb begin
    next_state = state;
    if (bus.wrEn) begin
      for (int i = 0; i < crs_pkg::NUM_RW; i++) begin
        if (bus.wrSel == 3'(i)) begin
          next_state.regs[i*crs_pkg::FIELD_WIDTH +: crs_pkg::FIELD_WIDTH] = bus.wrData;
        end
      end
    end
  end

  // register update with reset values
  always_ff @(posedge clk) begin
    if (reset) begin
      state.regs <= RESET_ALL;
    end else begin
      state <= next_state;
    end
  end

  assign bus.regs = state.regs;
endmodule : crs_reg_store

// ===== design/crs_regs.sv
// apb register bank of the clock route switch card with switch control outputs
// Contract
// - board id and three extended id bytes read back as fixed constants
// - fab, assembly and firmware revision registers are read only
// - t1 route resets 0xf; bits 3..0 zero close master, tx, rxsys, txsys switches
// - e1 route resets 0x3; bits 3..0 zero close the same four clock switches
// - link a resets 0xf; zero bits link sync and three clocks to rx side
// - link b resets 0x3; zero bits link cell clocks, serial loop, sync loop
// - level bit 2 zero enables cell bus header switches; reset 0x6
// - level bit 1 zero enables tdm bus header switches
// - level bit 0 drives backplane select, 0 tdm, 1 cell bus
// - bank answers from index zero up to level register index
module crs_regs #(
  parameter logic [7:0] BOARD_ID = 8'h01, // arbitrary value
  parameter logic [7:0] EXT_ID_HIGH = 8'h02, // arbitrary value
  parameter logic [7:0] EXT_ID_MID = 8'h03, // arbitrary value
  parameter logic [7:0] EXT_ID_LOW = 8'h04, // arbitrary value
  parameter logic [7:0] FAB_REV = 8'h01, // arbitrary value
  parameter logic [7:0] ASSEMBLY_REV = 8'h01, // arbitrary value
  parameter logic [7:0] FIRMWARE_REV = 8'h01 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [3:0] t1ClockSwitchN,
  output logic [3:0] e1ClockSwitchN,
  output logic [3:0] pinLinkASwitchN,
  output logic [3:0] pinLinkBSwitchN,
  output logic cellHeaderEnableN,
  output logic tdmHeaderEnableN,
  output logic backplaneSelect
);
  typedef struct packed {
    logic [31:0] rdata;
  } crs_regs_s;

  crs_regs_s state;
  crs_regs_s next_state;
  crs_bus_if bus ();

  logic [7:0] regIndex;
  logic aligned;
  logic inWindow;
  logic setupPhase;
  logic [3:0] t1Route;
  logic [3:0] e1Route;
  logic [3:0] linkA;
  logic [3:0] linkB;
  logic [3:0] levelReg;
  logic [7:0] readValue;

  // =====================================================
  // address decode: word aligned, index in the low bank window
  assign regIndex = paddr[crs_pkg::WORD_SHIFT +: crs_pkg::ADDR_WIDTH];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[31:crs_pkg::WORD_SHIFT + crs_pkg::ADDR_WIDTH] == 22'h000000);
  assign inWindow = aligned && (regIndex <= crs_pkg::IDX_LEVEL);
  assign setupPhase = psel && !penable;

  // register fields from storage
  assign t1Route = bus.regs[3:0];
  assign e1Route = bus.regs[7:4];
  assign linkA = bus.regs[11:8];
  assign linkB = bus.regs[15:12];
  assign levelReg = bus.regs[19:16];

  // =====================================================
  // write strobe only in access phase for writable indices
  always_comb begin
    bus.wrEn = 1'b0;
    bus.wrSel = 3'h0;
    bus.wrData = pwdata[3:0];
    if (psel && penable && pwrite && inWindow) begin
      unique case (regIndex)
        crs_pkg::IDX_T1_ROUTE: begin
          bus.wrEn = 1'b1;
          bus.wrSel = 3'h0;
        end
        crs_pkg::IDX_E1_ROUTE: begin
          bus.wrEn = 1'b1;
          bus.wrSel = 3'h1;
        end
        crs_pkg::IDX_LINK_A: begin
          bus.wrEn = 1'b1;
          bus.wrSel = 3'h2;
        end
        crs_pkg::IDX_LINK_B: begin
          bus.wrEn = 1'b1;
          bus.wrSel = 3'h3;
        end
        crs_pkg::IDX_LEVEL: begin
          bus.wrEn = 1'b1;
          bus.wrSel = 3'h4;
        end
        default: begin
          bus.wrEn = 1'b0; // read only and unmapped indices ignore writes
        end
      endcase
    end
  end

  // =====================================================
  // read mux: constants, revisions and writable nibbles
  always_comb begin
    readValue = 8'h00;
    if (inWindow) begin
      unique case (regIndex)
        crs_pkg::IDX_BOARD_ID: readValue = BOARD_ID;
        crs_pkg::IDX_EXT_ID_HIGH: readValue = EXT_ID_HIGH;
        crs_pkg::IDX_EXT_ID_MID: readValue = EXT_ID_MID;
        crs_pkg::IDX_EXT_ID_LOW: readValue = EXT_ID_LOW;
        crs_pkg::IDX_FAB_REV: readValue = FAB_REV;
        crs_pkg::IDX_ASSEMBLY_REV: readValue = ASSEMBLY_REV;
        crs_pkg::IDX_FIRMWARE_REV: readValue = FIRMWARE_REV;
        crs_pkg::IDX_T1_ROUTE: readValue = {4'h0, t1Route};
        crs_pkg::IDX_E1_ROUTE: readValue = {4'h0, e1Route};
        crs_pkg::IDX_LINK_A: readValue = {4'h0, linkA};
        crs_pkg::IDX_LINK_B: readValue = {4'h0, linkB};
        crs_pkg::IDX_LEVEL: readValue = {4'h0, levelReg};
        default: readValue = 8'h00; // unassigned offsets read zero
      endcase
    end
  end

  // read data captured in the setup cycle, held through access
  always_comb begin
    next_state = state;
    if (setupPhase) begin
      next_state.rdata = {24'h000000, readValue};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state.rdata <= 32'h00000000;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================
  // storage of writable registers
  crs_reg_store store_inst (
    .clk(clk),
    .reset(reset),
    .bus(bus)
  );

  // apb answer: zero wait states, no error
  assign prdata = state.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // =====================================================
  // switch outputs follow register bits without delay
  assign t1ClockSwitchN = t1Route;
  assign e1ClockSwitchN = e1Route;
  assign pinLinkASwitchN = linkA;
  assign pinLinkBSwitchN = linkB;
  assign cellHeaderEnableN = levelReg[crs_pkg::BIT_CELL_HDR];
  assign tdmHeaderEnableN = levelReg[crs_pkg::BIT_TDM_HDR];
  assign backplaneSelect = levelReg[crs_pkg::BIT_BP_SEL];

  // =====================================================
  // checks
  chk_level_reset: assert property (@(posedge clk) $fell(reset) |->
    (cellHeaderEnableN && tdmHeaderEnableN && !backplaneSelect))
    else $error("level pins wrong after reset");
  chk_t1_reset: assert property (@(posedge clk) $fell(reset) |-> t1ClockSwitchN == crs_pkg::RST_T1_ROUTE)
    else $error("t1 route reset wrong");
  chk_e1_reset: assert property (@(posedge clk) $fell(reset) |-> e1ClockSwitchN == crs_pkg::RST_E1_ROUTE)
    else $error("e1 route reset wrong");
  chk_linka_reset: assert property (@(posedge clk) $fell(reset) |-> pinLinkASwitchN == crs_pkg::RST_LINK_A)
    else $error("link a reset wrong");
  chk_linkb_reset: assert property (@(posedge clk) $fell(reset) |-> pinLinkBSwitchN == crs_pkg::RST_LINK_B)
    else $error("link b reset wrong");
  chk_write_lands: assert property (@(posedge clk) disable iff (reset)
    (psel && penable && pwrite && aligned && regIndex == crs_pkg::IDX_LEVEL) |=>
    ({cellHeaderEnableN, tdmHeaderEnableN, backplaneSelect} == $past(pwdata[2:0])))
    else $error("level write not applied");
  chk_ro_ignored: assert property (@(posedge clk) disable iff (reset)
    (psel && penable && pwrite && regIndex < crs_pkg::IDX_T1_ROUTE) |=> $stable(bus.regs))
    else $error("read only write changed state");
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
    (setupPhase && !inWindow) |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_id_read: assert property (@(posedge clk) disable iff (reset)
    (setupPhase && aligned && regIndex == crs_pkg::IDX_BOARD_ID) |=> prdata[7:0] == BOARD_ID)
    else $error("board id read wrong");
  chk_upper_zero: assert property (@(posedge clk) disable iff (reset)
    (setupPhase && aligned && regIndex >= crs_pkg::IDX_T1_ROUTE) |=> prdata[31:4] == 28'h0000000)
    else $error("upper bits not zero");

  // =====================================================
  // constant registers read back their parameters, unused bits and gaps read zero
  chk_ext_high_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_EXT_ID_HIGH)
    |=> prdata == {24'h000000, EXT_ID_HIGH})
    else $error("extended id high read wrong");
  chk_ext_mid_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_EXT_ID_MID)
    |=> prdata == {24'h000000, EXT_ID_MID})
    else $error("extended id mid read wrong");
  chk_ext_low_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_EXT_ID_LOW)
    |=> prdata == {24'h000000, EXT_ID_LOW})
    else $error("extended id low read wrong");
  chk_fab_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_FAB_REV)
    |=> prdata == {24'h000000, FAB_REV})
    else $error("fab revision read wrong");
  chk_assembly_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_ASSEMBLY_REV)
    |=> prdata == {24'h000000, ASSEMBLY_REV})
    else $error("assembly revision read wrong");
  chk_firmware_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_FIRMWARE_REV)
    |=> prdata == {24'h000000, FIRMWARE_REV})
    else $error("firmware revision read wrong");
  chk_ro_upper_zero: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex <= crs_pkg::IDX_FIRMWARE_REV)
    |=> prdata[31:8] == 24'h000000)
    else $error("read only upper bits not zero");
  chk_gap_read_zero: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex > crs_pkg::IDX_FIRMWARE_REV && regIndex < crs_pkg::IDX_T1_ROUTE)
    |=> prdata == 32'h00000000)
    else $error("gap read not zero");

  // a write to a route or link register shows on its switch pins one cycle later
  chk_t1_write: assert property (@(posedge clk) disable iff (reset)
    (!reset && psel && penable && pwrite && aligned && regIndex == crs_pkg::IDX_T1_ROUTE)
    |=> t1ClockSwitchN == $past(pwdata[3:0]))
    else $error("t1 route write not applied");
  chk_e1_write: assert property (@(posedge clk) disable iff (reset)
    (!reset && psel && penable && pwrite && aligned && regIndex == crs_pkg::IDX_E1_ROUTE)
    |=> e1ClockSwitchN == $past(pwdata[3:0]))
    else $error("e1 route write not applied");
  chk_linka_write: assert property (@(posedge clk) disable iff (reset)
    (!reset && psel && penable && pwrite && aligned && regIndex == crs_pkg::IDX_LINK_A)
    |=> pinLinkASwitchN == $past(pwdata[3:0]))
    else $error("link a write not applied");
  chk_linkb_write: assert property (@(posedge clk) disable iff (reset)
    (!reset && psel && penable && pwrite && aligned && regIndex == crs_pkg::IDX_LINK_B)
    |=> pinLinkBSwitchN == $past(pwdata[3:0]))
    else $error("link b write not applied");

  // reads of writable registers return what the pins show
  chk_t1_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_T1_ROUTE)
    |=> prdata == {28'h0000000, $past(t1ClockSwitchN)})
    else $error("t1 route read wrong");
  chk_e1_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_E1_ROUTE)
    |=> prdata == {28'h0000000, $past(e1ClockSwitchN)})
    else $error("e1 route read wrong");
  chk_linka_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_LINK_A)
    |=> prdata == {28'h0000000, $past(pinLinkASwitchN)})
    else $error("link a read wrong");
  chk_linkb_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_LINK_B)
    |=> prdata == {28'h0000000, $past(pinLinkBSwitchN)})
    else $error("link b read wrong");
  chk_level_read: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase && aligned && regIndex == crs_pkg::IDX_LEVEL)
    |=> prdata[2:0] == $past({cellHeaderEnableN, tdmHeaderEnableN, backplaneSelect}))
    else $error("level read wrong");

  // state and read data change only where a transfer allows it
  chk_unmapped_write: assert property (@(posedge clk) disable iff (reset)
    (!reset && psel && penable && pwrite && !inWindow)
    |=> $stable(bus.regs))
    else $error("unmapped write changed state");
  chk_setup_no_write: assert property (@(posedge clk) disable iff (reset)
    (!reset && setupPhase)
    |=> $stable(bus.regs))
    else $error("setup cycle changed state");
  chk_read_no_write: assert property (@(posedge clk) disable iff (reset)
    (!reset && psel && penable && !pwrite)
    |=> $stable(bus.regs))
    else $error("read access changed state");
  chk_pins_hold: assert property (@(posedge clk) disable iff (reset)
    (!reset && !(psel && penable && pwrite))
    |=> $stable({t1ClockSwitchN, e1ClockSwitchN, pinLinkASwitchN, pinLinkBSwitchN,
      cellHeaderEnableN, tdmHeaderEnableN, backplaneSelect}))
    else $error("switch pins moved without a write");
  chk_rdata_hold: assert property (@(posedge clk) disable iff (reset)
    (!reset && !setupPhase)
    |=> $stable(prdata))
    else $error("read data moved outside setup");
  chk_wrsel_range: assert property (@(posedge clk) disable iff (reset)
    bus.wrEn
    |-> bus.wrSel < 3'(crs_pkg::NUM_RW))
    else $error("write select out of range");
endmodule : crs_regs

// ===== sim/crs_host_model.sv
// apb host model standing for the motherboard processor
module crs_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  // =====================================================
  // one transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // released lines do not keep the old value
    pwdata <= ~d;
  endtask : xfer
endmodule : crs_host_model

// ===== sim/testbench.sv
// self-checking bench of the clock route switch register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [55:0] IDS = 56'h5a_a1_b2_c3_17_28_39; // arbitrary values
  logic clk, reset, psel, penable, pwrite, pready, pslverr, cellN, tdmN, bp;
  logic [31:0] paddr, pwdata, prdata, seed;
  logic [3:0] t1, e1, la, lb;
  logic [3:0] sh [5];
  logic [7:0] idx;
  logic [31:0] d;
  int errors = 0;
  int compares = 0;
  // =====================================================
  // clock, device and host
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  crs_regs #(.BOARD_ID(IDS[55:48]), .EXT_ID_HIGH(IDS[47:40]), .EXT_ID_MID(IDS[39:32]), .EXT_ID_LOW(IDS[31:24]),
    .FAB_REV(IDS[23:16]), .ASSEMBLY_REV(IDS[15:8]), .FIRMWARE_REV(IDS[7:0])) i_dut (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .t1ClockSwitchN(t1), .e1ClockSwitchN(e1), .pinLinkASwitchN(la),
    .pinLinkBSwitchN(lb), .cellHeaderEnableN(cellN), .tdmHeaderEnableN(tdmN), .backplaneSelect(bp));
  crs_host_model i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready));
  // =====================================================
  // expectations
  function automatic logic [31:0] exp_read(logic [31:0] a);
    if (a[1:0] != 2'b00 || a[31:10] != 22'h0) return 32'h0;
    if (a[9:2] <= 8'h07 && a[9:2] != 8'h01) return {24'h0, IDS[8 * (6 - (a[9:2] == 0 ? 0 : a[9:2] - 1)) +: 8]};
    if (a[9:2] >= 8'h11 && a[9:2] <= 8'h15) return {28'h0, sh[a[9:2] - 8'h11]};
    return 32'h0;
  endfunction : exp_read
  task automatic rst_shadow;
    sh = '{crs_pkg::RST_T1_ROUTE, crs_pkg::RST_E1_ROUTE, crs_pkg::RST_LINK_A, crs_pkg::RST_LINK_B, crs_pkg::RST_LEVEL};
  endtask : rst_shadow
  task automatic report(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : report
  task automatic cmp_read(logic [31:0] got, logic [31:0] exp);
    report(got, exp);
  endtask : cmp_read
  task automatic cmp_pins;
    report({13'h0, t1, e1, la, lb, cellN, tdmN, bp}, {13'h0, sh[0], sh[1], sh[2], sh[3], sh[4][2:0]});
  endtask : cmp_pins
  task automatic cmp_resp(logic [1:0] got);
    report({30'h0, got}, 32'h2);
  endtask : cmp_resp
  // one bus access; writes update the shadow and check the pins
  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] dv);
    logic [31:0] q, e;
    e = exp_read(a);
    i_host.xfer(wr, a, dv, q);
    cmp_resp({pready, pslverr});
    if (wr) begin
      if (a[1:0] == 2'b00 && a[31:10] == 22'h0 && a[9:2] >= 8'h11 && a[9:2] <= 8'h15) sh[a[9:2] - 8'h11] = dv[3:0];
      #1;
      cmp_pins();
    end else begin
      cmp_read(q, e);
    end
  endtask : acc
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // =====================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  // =====================================================
  // main sequence
  initial begin
    seed = 32'hc154;
    reset = 1'b1;
    rst_shadow();
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    cmp_pins();
    for (int i = 0; i < 24; i++) acc(1'b0, i * 4, 32'h0);
    acc(1'b0, 32'h45, 32'h0);
    acc(1'b0, 32'h444, 32'h0);
    for (int i = 0; i < 24; i++) acc(1'b1, i * 4, 32'hffff_fffe);
    acc(1'b1, 32'h45, 32'h0);
    acc(1'b1, 32'h444, 32'h0);
    for (int i = 0; i < 24; i++) acc(1'b0, i * 4, 32'h0);
    // contention switches opened before the cell backplane is chosen
    acc(1'b1, 32'h44, 32'h1);
    acc(1'b1, 32'h48, 32'h9);
    acc(1'b1, 32'h4c, 32'h1);
    acc(1'b1, 32'h54, 32'h7);
    acc(1'b1, 32'h54, 32'h0);
    repeat (60) begin
      idx = 8'h11 + 8'($unsigned($random(seed)) % 5);
      d = $random(seed);
      if (idx == 8'h11 && sh[1][3] == 1'b0) d[3] = 1'b1;
      if (idx == 8'h12 && sh[0][3] == 1'b0) d[3] = 1'b1;
      if (sh[4][0] && idx <= 8'h13) d[0] = 1'b1;
      if (sh[4][0] && idx == 8'h14) d[1] = 1'b1;
      if (idx == 8'h15 && !(sh[0][0] && sh[1][0] && sh[2][0] && sh[3][1])) d[0] = 1'b0;
      acc(1'b1, {22'h0, idx, 2'b00}, d);
      acc(1'b0, {22'h0, idx, 2'b00}, 32'h0);
    end
    // reset in mid run restores every writable register
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rst_shadow();
    #1;
    cmp_pins();
    acc(1'b0, 32'h54, 32'h0);
    end_of_test();
  end
endmodule : testbench
